/* File: shared/hbp_cfg.svh */
// offsets, field positions, reset values and timing counts of the pwm stage
`ifndef HBP_CFG_SVH
`define HBP_CFG_SVH

`define HBP_ADDR_W 5
`define HBP_OFS_UNIT_CTRL 5'h00
`define HBP_OFS_PERIOD 5'h04
`define HBP_OFS_TIMER_CTRL 5'h08
`define HBP_OFS_DUTY 5'h0c
`define HBP_OFS_DEAD_BAND 5'h10
`define HBP_OFS_PIN_DIR 5'h14
`define HBP_OFS_STATUS 5'h18

`define HBP_UC_EN_BIT 0
`define HBP_UC_HALF_BIT 1
`define HBP_UC_DLSB_LO 4
`define HBP_UC_DLSB_HI 5
`define HBP_TC_PS_LO 0
`define HBP_TC_PS_HI 1
`define HBP_TC_ON_BIT 2

`define HBP_RST_UNIT_CTRL 8'h00
`define HBP_RST_PERIOD 8'hff
`define HBP_RST_TIMER_CTRL 3'h0
`define HBP_RST_DUTY 8'h00
`define HBP_RST_DEAD_BAND 7'h00
`define HBP_RST_PIN_DIR 2'h3

// one instruction cycle is four clock cycles
`define HBP_CLKS_PER_INSTR 4
`define HBP_INSTR_SHIFT 2

`endif

/* File: shared/hbp_pkg.sv */
// types of the half-bridge pwm stage
package hbp_pkg;

  typedef enum logic [1:0] {
    HBP_PS_DIV1 = 2'h0,
    HBP_PS_DIV4 = 2'h1,
    HBP_PS_DIV16 = 2'h2,
    HBP_PS_DIV16B = 2'h3
  } hbp_presc_t;

  typedef logic [9:0] hbp_count10_t;

endpackage

/* File: verilog/hbp_pwm.sv */
// half-bridge pwm output stage with avalon-mm register slave
//
// How it works
// RL1: pwm waveform of ten-bit duty resolution driven on the primary pin.
// RL2: period, duty, resolution come only from period, timer, duty, unit registers.
// RL3: primary pin driver enabled only while its direction bit is cleared.
// RL4: each cycle is a period time base with a high duty portion.
// RL5: half-bridge mode drives pwm on pin a, complement on pin b.
// RL6: seven-bit dead-band count delays each output going active in half-bridge mode, in instruction cycles.
// RL7: dead band longer than the phase keeps that output inactive whole cycle.
// RL8: each bridge pin driven only while its own direction bit is cleared.
// RL9: output goes high at period match, low when timer reaches duty value.
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`include "hbp_cfg.svh"

module hbp_pwm
  import hbp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [`HBP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic primary_pwm_pin,
  output logic primary_pwm_pin_oe,
  output logic bridge_output_b,
  output logic bridge_output_b_oe
);

  // ****************************************
  // register slave
  // ****************************************
  logic [7:0] unit_control_reg;
  logic [7:0] period_reg;
  logic [2:0] period_timer_control;
  logic [7:0] duty_cycle_reg;
  logic [6:0] dead_band_control_reg;
  logic [1:0] pin_direction_reg;
  logic ack_reg;
  logic wr_take;
  logic [31:0] rd_next;
  hbp_count10_t tmr_reg;
  logic pwm_reg;

  // one wait state, answer on second cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_take = avs_write & ack_reg & avs_byteenable[0];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
  end

  always_comb
  begin
    rd_next = 32'h0000_0000;
    unique case (avs_address)
      `HBP_OFS_UNIT_CTRL: rd_next[7:0] = unit_control_reg;
      `HBP_OFS_PERIOD: rd_next[7:0] = period_reg;
      `HBP_OFS_TIMER_CTRL: rd_next[2:0] = period_timer_control;
      `HBP_OFS_DUTY: rd_next[7:0] = duty_cycle_reg;
      `HBP_OFS_DEAD_BAND: rd_next[6:0] = dead_band_control_reg;
      `HBP_OFS_PIN_DIR: rd_next[1:0] = pin_direction_reg;
      `HBP_OFS_STATUS: rd_next[12:0] = {primary_pwm_pin, bridge_output_b, pwm_reg, tmr_reg};
      default: rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & ~ack_reg)
      avs_readdata <= rd_next;
  end

  // RL2 register writes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      unit_control_reg <= `HBP_RST_UNIT_CTRL;
      period_reg <= `HBP_RST_PERIOD;
      period_timer_control <= `HBP_RST_TIMER_CTRL;
      duty_cycle_reg <= `HBP_RST_DUTY;
      dead_band_control_reg <= `HBP_RST_DEAD_BAND;
      pin_direction_reg <= `HBP_RST_PIN_DIR;
    end
    else if (wr_take)
    begin
      unique case (avs_address)
        `HBP_OFS_UNIT_CTRL: unit_control_reg <= avs_writedata[7:0];
        `HBP_OFS_PERIOD: period_reg <= avs_writedata[7:0];
        `HBP_OFS_TIMER_CTRL: period_timer_control <= avs_writedata[2:0];
        `HBP_OFS_DUTY: duty_cycle_reg <= avs_writedata[7:0];
        `HBP_OFS_DEAD_BAND: dead_band_control_reg <= avs_writedata[6:0];
        `HBP_OFS_PIN_DIR: pin_direction_reg <= avs_writedata[1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // period timer
  // ****************************************
  logic pwm_en;
  logic half_mode;
  logic timer_on;
  hbp_presc_t presc;
  logic [3:0] ps_cnt_reg;
  logic [3:0] ps_mask;
  logic tick;
  hbp_count10_t duty10;
  hbp_count10_t tmr_inc;
  logic period_end;

  assign pwm_en = unit_control_reg[`HBP_UC_EN_BIT];
  assign half_mode = unit_control_reg[`HBP_UC_HALF_BIT];
  assign timer_on = period_timer_control[`HBP_TC_ON_BIT];
  assign presc = hbp_presc_t'(period_timer_control[`HBP_TC_PS_HI:`HBP_TC_PS_LO]);
  assign ps_mask = (presc == HBP_PS_DIV1) ? 4'h0 : ((presc == HBP_PS_DIV4) ? 4'h3 : 4'hf);
  assign tick = timer_on & ((ps_cnt_reg & ps_mask) == ps_mask);
  // RL1 ten-bit duty value
  assign duty10 = {duty_cycle_reg, unit_control_reg[`HBP_UC_DLSB_HI:`HBP_UC_DLSB_LO]};
  assign tmr_inc = tmr_reg + 10'h001;
  // RL4 period time base ends at period match
  assign period_end = (tmr_reg[9:2] == period_reg) & (tmr_reg[1:0] == 2'h3);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ps_cnt_reg <= 4'h0;
    else if (!timer_on | tick)
      ps_cnt_reg <= 4'h0;
    else
      ps_cnt_reg <= ps_cnt_reg + 4'h1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tmr_reg <= 10'h000;
    else if (tick)
      tmr_reg <= period_end ? 10'h000 : tmr_inc;
  end

  // RL9 set at period start, clear at duty match
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pwm_reg <= 1'b0;
    else if (!pwm_en)
      pwm_reg <= 1'b0;
    else if (tick & period_end)
      pwm_reg <= (duty10 != 10'h000);
    else if (tick & (tmr_inc == duty10))
      pwm_reg <= 1'b0;
  end

  // ****************************************
  // dead band and pins
  // ****************************************
  logic pwm_d_reg;
  logic [8:0] db_cnt_reg;
  logic db_ok;
  logic a_next;
  logic b_next;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pwm_d_reg <= 1'b0;
    else
      pwm_d_reg <= pwm_reg;
  end

  // RL6 count clocks since last edge, saturating
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      db_cnt_reg <= 9'h000;
    else if (pwm_reg != pwm_d_reg)
      db_cnt_reg <= 9'h001;
    else if (db_cnt_reg != 9'h1ff)
      db_cnt_reg <= db_cnt_reg + 9'h001;
  end

  // RL7 edge ends phase before delay expires
  assign db_ok = (pwm_reg == pwm_d_reg) ? (db_cnt_reg >= {dead_band_control_reg, 2'h0}) :
                                          (dead_band_control_reg == 7'h00);
  // RL5 complementary pair in half-bridge mode
  assign a_next = half_mode ? (pwm_reg & db_ok) : pwm_reg;
  assign b_next = pwm_en & half_mode & ~pwm_reg & db_ok;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      primary_pwm_pin <= 1'b0;
      bridge_output_b <= 1'b0;
      primary_pwm_pin_oe <= 1'b0;
      bridge_output_b_oe <= 1'b0;
    end
    else
    begin
      primary_pwm_pin <= a_next;
      bridge_output_b <= b_next;
      // RL3 direction gates primary driver
      primary_pwm_pin_oe <= pwm_en & ~pin_direction_reg[0];
      // RL8 direction gates bridge driver
      bridge_output_b_oe <= pwm_en & half_mode & ~pin_direction_reg[1];
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  // length of the current pwm high run, helper for the dead band check
  logic [8:0] hi_run_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      hi_run_reg <= 9'h000;
    else if (!pwm_reg)
      hi_run_reg <= 9'h000;
    else if (hi_run_reg != 9'h1ff)
      hi_run_reg <= hi_run_reg + 9'h001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_OE_A: assert property (primary_pwm_pin_oe == $past(pwm_en & ~pin_direction_reg[0])) // RL3
    else $error("primary oe does not follow direction bit");
  AST_OE_B: assert property (bridge_output_b_oe |-> !$past(pin_direction_reg[1])) // RL8
    else $error("bridge b driven with direction set");
  AST_NO_OVERLAP: assert property (!(primary_pwm_pin & bridge_output_b)) // RL6
    else $error("both bridge outputs active");
  AST_RISE: assert property (pwm_en & tick & period_end & (duty10 != 10'h000) // RL9
    ##1 pwm_en |-> pwm_reg)
    else $error("pwm did not rise at period match");
  AST_FALL: assert property (pwm_en & tick & !period_end & (tmr_inc == duty10) // RL9
    |=> !pwm_reg)
    else $error("pwm did not fall at duty match");
  AST_TIMER_WRAP: assert property (tick & period_end |=> tmr_reg == 10'h000) // RL4
    else $error("timer did not restart at period end");
  AST_SINGLE: assert property (!$past(half_mode) |-> primary_pwm_pin == $past(pwm_reg)) // RL1
    else $error("primary pin does not follow pwm");
  AST_COMP: assert property ($past(half_mode & db_ok & pwm_en) // RL5
    |-> bridge_output_b == !primary_pwm_pin)
    else $error("bridge b not complement of a");
  AST_DB_HOLD: assert property ($rose(pwm_reg) & half_mode & // RL7
    (dead_band_control_reg != 7'h00) |=> !primary_pwm_pin)
    else $error("pin a active before dead band");
  AST_DB_A: assert property ($rose(primary_pwm_pin) & $past(half_mode) |-> // RL6
    $past(hi_run_reg) >= {$past(dead_band_control_reg), 2'h0})
    else $error("pin a active before dead band elapsed");
  AST_DIS: assert property (!pwm_en |=> !pwm_reg) // RL2
    else $error("pwm active while unit disabled");

  COV_HALF: cover property (half_mode & primary_pwm_pin ##[1:600] bridge_output_b);
  COV_DB: cover property (half_mode & (dead_band_control_reg != 7'h00) & $rose(primary_pwm_pin));
  COV_WRAP: cover property (tick & period_end & pwm_en);

endmodule

/* File: testbench/hbp_switches.sv */
// push-pull switch pair on the two bridge pins
`timescale 1ns/1ps
module hbp_switches
(
  input wire logic clk,
  input wire logic hi_gate,
  input wire logic hi_oe,
  input wire logic lo_gate,
  input wire logic lo_oe,
  output int shoot
);
  // each switch keeps conducting two clocks after its gate drops
  logic [1:0] hi_tail = 2'h0;
  logic [1:0] lo_tail = 2'h0;
  logic hi_on;
  logic lo_on;
  int overlap_cnt = 0;

  assign hi_on = (hi_gate & hi_oe) | (|hi_tail);
  assign lo_on = (lo_gate & lo_oe) | (|lo_tail);
  assign shoot = overlap_cnt;

  always @(posedge clk)
  begin
    hi_tail <= {hi_tail[0], hi_gate & hi_oe};
    lo_tail <= {lo_tail[0], lo_gate & lo_oe};
  end

  always @(posedge clk)
  begin
    if (hi_on === 1'b1 && lo_on === 1'b1)
      overlap_cnt <= overlap_cnt + 1;
  end
endmodule

/* File: testbench/test_hbp_pwm.sv */
// self-checking bench of the half-bridge pwm stage
`timescale 1ns/1ps
`include "hbp_cfg.svh"
module test_hbp_pwm;
  logic clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [`HBP_ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic pa, pa_oe, pb, pb_oe;
  logic [7:0] rnd;
  logic [31:0] exp_q[$];
  int miscompares, num_checks, cycles, shoot, ca, cb;

  hbp_pwm hbp_pwm_inst (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .primary_pwm_pin(pa),
    .primary_pwm_pin_oe(pa_oe), .bridge_output_b(pb), .bridge_output_b_oe(pb_oe));
  hbp_switches hbp_switches_inst (.clk(clk), .hi_gate(pa), .hi_oe(pa_oe),
    .lo_gate(pb), .lo_oe(pb_oe), .shoot(shoot));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic close_out();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want)
    begin
      miscompares++;
      $display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // ***********
  // bus master
  // ***********
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d,
    input logic [3:0] be);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 4'h1);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0, 4'h1);
  endtask

  task automatic meas(input int n);
    ca = 0;
    cb = 0;
    repeat (n)
    begin
      @(posedge clk);
      ca += (pa === 1'b1);
      cb += (pb === 1'b1);
    end
  endtask

  always @(posedge clk)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      chk(avs_readdata, exp_q.pop_front());
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      close_out();
    end
  end

  initial
  begin
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = '0;
    rnd = 8'h4a;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(`HBP_OFS_UNIT_CTRL, 32'(`HBP_RST_UNIT_CTRL));
    rd(`HBP_OFS_PERIOD, 32'(`HBP_RST_PERIOD));
    rd(`HBP_OFS_TIMER_CTRL, 32'(`HBP_RST_TIMER_CTRL));
    rd(`HBP_OFS_DUTY, 32'(`HBP_RST_DUTY));
    rd(`HBP_OFS_DEAD_BAND, 32'(`HBP_RST_DEAD_BAND));
    rd(`HBP_OFS_PIN_DIR, 32'(`HBP_RST_PIN_DIR));
    bus(`HBP_OFS_PERIOD, 1'b1, 32'h3, 4'h0);
    wr(5'h1c, 32'hff);
    rd(5'h1c, 32'h0);
    rd(`HBP_OFS_PERIOD, 32'hff);
    chk(32'({pb_oe, pa_oe}), 32'h0);
    wr(`HBP_OFS_PIN_DIR, 32'h2);
    wr(`HBP_OFS_PERIOD, 32'h0);
    for (int p = 0; p < 4; p++)
    begin
      int dv;
      dv = (p == 0) ? 1 : (p == 1) ? 4 : 16;
      rnd = lfsr(rnd);
      wr(`HBP_OFS_TIMER_CTRL, 32'(p) | 32'h4);
      wr(`HBP_OFS_UNIT_CTRL, {26'h0, rnd[1:0], 4'h1});
      repeat (dv * 8) @(posedge clk);
      meas(dv * 16);
      chk(32'(ca), 32'(rnd[1:0] * dv * 4));
      chk(32'({pb_oe, pa_oe}), 32'h1);
    end
    // half bridge, dead band 4 clocks
    wr(`HBP_OFS_PIN_DIR, 32'h0);
    wr(`HBP_OFS_PERIOD, 32'h3);
    wr(`HBP_OFS_TIMER_CTRL, 32'h4);
    wr(`HBP_OFS_DUTY, 32'h2);
    wr(`HBP_OFS_DEAD_BAND, 32'h1);
    wr(`HBP_OFS_UNIT_CTRL, 32'h3);
    repeat (32) @(posedge clk);
    meas(64);
    chk(32'(ca), 32'd16);
    chk(32'(cb), 32'd16);
    chk(32'({pb_oe, pa_oe}), 32'h3);
    wr(`HBP_OFS_DEAD_BAND, 32'h3);
    rd(`HBP_OFS_DEAD_BAND, 32'h3);
    repeat (32) @(posedge clk);
    meas(64);
    chk(32'(ca + cb), 32'd0);
    chk(32'(shoot), 32'd0);
    // direction bits release the pins while enabled
    wr(`HBP_OFS_PIN_DIR, 32'h3);
    repeat (2) @(posedge clk);
    chk(32'(pa_oe), 32'h0);
    chk(32'(pb_oe), 32'h0);
    wr(`HBP_OFS_PIN_DIR, 32'h0);
    wr(`HBP_OFS_UNIT_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    chk(32'({pb_oe, pa_oe, pb, pa}), 32'h0);
    close_out();
  end
endmodule
